// ### hdl/adb_cfg.svh
// constants of the converter digital back end
`ifndef ADB_CFG_SVH
`define ADB_CFG_SVH
`define ADB_PIPE_STAGES 7
`define ADB_FIFO_DEPTH 16
`define ADB_WORD_W 11
`define ADB_SELF_TEST_CYCLES 10'h200
`define ADB_INSTR_BITS 5'h10
`define ADB_BYTE_LAST 3'h7
`define ADB_A_PORTCFG 13'h000
`define ADB_A_OUTMODE 13'h008
`define ADB_A_TESTPAT 13'h00d
`define ADB_A_SELF_TEST 13'h00e
`define ADB_A_FORMAT 13'h014
`define ADB_A_CLKPOL 13'h016
`define ADB_A_RESULT 13'h024
`define ADB_A_TRANSFER 13'h0ff
`define ADB_OEB_MSB 6
`define ADB_OEB_LSB 5
`define ADB_OEB_SEL 2'h1
`define ADB_LSB_FIRST_BIT 6
`define ADB_SELF_TEST_EN_BIT 0
`define ADB_SELF_TEST_SEED_RESET_BIT 2
`define ADB_PN_LONG_RST_BIT 4
`define ADB_PN_SHORT_RST_BIT 5
`define ADB_XFER_BIT 0
`define ADB_PASS_BIT 0
`define ADB_CLKPOL_BIT 7
`define ADB_PN_LONG_SEED 10'h3ff
`define ADB_PN_SHORT_SEED 9'h1ff
`define ADB_CRC_SEED 16'hffff
`define ADB_CRC_POLY 16'h1021
`define ADB_CODE_MID 10'h200
`define ADB_CODE_POSFS 10'h3ff
`define ADB_CODE_NEGFS 10'h000
`define ADB_CODE_CHECK 10'h155
`define ADB_TP_MID 4'h1
`define ADB_TP_POSFS 4'h2
`define ADB_TP_NEGFS 4'h3
`define ADB_TP_CHECK 4'h4
`define ADB_TP_PN_LONG 4'h5
`define ADB_TP_PN_SHORT 4'h6
`define ADB_TP_TOGGLE 4'h7
`endif

// ### hdl/adb_pkg.sv
// types of the converter digital back end
package adb_pkg;
	typedef enum logic [2:0] {ADB_SP_IDLE = 3'h1, ADB_SP_INSTR = 3'h2, ADB_SP_DATA = 3'h4} adb_sp_state_t;
	typedef enum logic [1:0] {ADB_FMT_OFFSET = 2'h0, ADB_FMT_TWOS = 2'h1, ADB_FMT_GRAY = 2'h2} adb_fmt_t;
endpackage : adb_pkg

// ### hdl/adb_backend.sv
// converter digital back end: formatter, latency pipe, output fifo, self-test and serial port
//
// Behaviour
// - each sample appears on the outputs eight sample ticks later while the fifo holds no backlog from a float, updated at a tick edge
// - strap mode: format strap low gives offset binary, high gives twos complement
// - serial configuration offers offset binary, twos complement and gray code
// - offset binary codes as given; twos complement inverts the top bit
// - mode pin output-float function selected by bits 6 to 5 of output_mode_control
// - float function selected: pin low drives data and capture clock, high floats both
// - capture clock rises mid-word, marking valid data, unless polarity is inverted
// - self-test drives pseudorandom data, accumulates a signature 512 ticks, then compares
// - self-test match sets result bit 0 at 0x24, mismatch clears it
// - writing 0x05 to 0x0e starts self-test with a reseeded pseudorandom source
// - seed-reset bit 0 lets the source continue, so after an earlier run the signature will not match
// - during self-test the outputs stay driven and show the pseudorandom words
// - a test pattern replaces converter samples and passes through the formatter
// - bits 4 and 5 of test_pattern_select reload the pattern generators
// - a frame starts on the first shift-clock rise after select falls
// - select held low keeps a streaming frame accepting bytes
// - select high between bytes pauses a fixed-length frame without losing its position
// - select never low: serial pins float and act as sleep and format straps
// - frames open with a 16-bit instruction whose two length bits count data bytes
// - data moves in 8-bit bytes; the first instruction bit, the last when least significant first, selects read or write
// - on a read the device drives the data pin after the instruction phase
// - bits go most significant first after reset; a port setting selects least first
// - writes to 0x08..0x18 wait until 0x01 is written to 0xff, then apply together
`timescale 1ns/1ns
`include "adb_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module adb_fifo #(
	parameter int WIDTH = `ADB_WORD_W,
	parameter int DEPTH = `ADB_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} adb_fifo_st_t;
	adb_fifo_st_t st;
	adb_fifo_st_t next_st;
	logic push;
	logic pop;

	assign in_ready = st.cnt != (AW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = st.mem[st.rp];

	always_comb
	begin
		next_st = st;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push)
		begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = st.rp + 1'b1;
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end
endmodule : adb_fifo

////////////////////////////////////////////////////////////////////////////////
module adb_backend #(
	parameter logic [15:0] SELF_TEST_SIGNATURE = 16'h0000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [9:0] sample_code,
	input wire logic sample_over,
	input wire logic sample_under,
	output logic sample_ready,
	input wire logic port_select_low,
	input wire logic shift_clock_format_strap,
	input wire logic serial_line_sleep_strap_in,
	output logic serial_line_sleep_strap_out,
	output logic serial_line_sleep_strap_oe,
	input wire logic output_float_control,
	output logic [9:0] data_out,
	output logic data_oe,
	output logic out_of_range,
	output logic data_capture_clock,
	output logic data_capture_clock_oe,
	output logic sleep_active
);
	typedef struct packed {
		logic [2:0] csq, sckq, sdiq, modq;
		logic cs_lvl, sck_lvl, sdi_lvl, mod_lvl;
		logic spi_seen, div, alt;
		logic [`ADB_PIPE_STAGES-1:0][`ADB_WORD_W-1:0] pipe;
		logic [9:0] pn_long;
		logic [8:0] pn_short;
		logic [9:0] self_test_pn;
		logic self_test_run;
		logic [9:0] self_test_cnt;
		logic [15:0] crc;
		adb_pkg::adb_sp_state_t sp;
		logic [4:0] instr_cnt;
		logic [2:0] bit_cnt;
		logic is_read, streaming;
		logic [1:0] bytes_left;
		logic [12:0] addr;
		logic [15:0] instr;
		logic [7:0] din, rd;
		logic [7:0] portcfg, sh_outmode, sh_testpat, sh_self_test, sh_format, sh_clkpol;
		logic [7:0] act_outmode, act_testpat, act_self_test, act_format, act_clkpol, result;
		logic [9:0] dout;
		logic oor, doe, cap, cap_oe, sdo, sdo_oe, sleep, rdy;
	} adb_st_t;
	adb_st_t st;
	adb_st_t next_st;
	logic tick, adv, fl, pop_ok, f_in_ready, f_out_valid;
	logic sck_rise, sck_fall, cs_rise, lsb, bitv, apply;
	logic [9:0] raw;
	logic [9:0] fmtd;
	logic [`ADB_WORD_W-1:0] word;
	logic [`ADB_WORD_W-1:0] f_out;
	logic [15:0] crc_new;
	logic [7:0] byte_in;
	adb_pkg::adb_fmt_t fmt;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [9:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 9; i >= 0; i--)
			r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `ADB_CRC_POLY) : {r[14:0], 1'b0};
		return r;
	endfunction : crc_step

	function automatic logic [7:0] reg_read(input adb_st_t s, input logic [12:0] a);
		case (a)
			`ADB_A_PORTCFG: reg_read = s.portcfg;
			`ADB_A_OUTMODE: reg_read = s.sh_outmode;
			`ADB_A_TESTPAT: reg_read = s.sh_testpat;
			`ADB_A_SELF_TEST: reg_read = s.sh_self_test;
			`ADB_A_FORMAT: reg_read = s.sh_format;
			`ADB_A_CLKPOL: reg_read = s.sh_clkpol;
			`ADB_A_RESULT: reg_read = s.result;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	adb_fifo #(.WIDTH(`ADB_WORD_W), .DEPTH(`ADB_FIFO_DEPTH)) u_fifo (
		.clk(sys_clk),
		.rst(rst),
		.in_valid(adv),
		.in_data(st.pipe[`ADB_PIPE_STAGES-1]),
		.in_ready(f_in_ready),
		.out_valid(f_out_valid),
		.out_data(f_out),
		.out_ready(pop_ok)
	);

	assign sample_ready = st.rdy;
	assign serial_line_sleep_strap_out = st.sdo;
	assign serial_line_sleep_strap_oe = st.sdo_oe;
	assign data_out = st.dout;
	assign data_oe = st.doe;
	assign out_of_range = st.oor;
	assign data_capture_clock = st.cap;
	assign data_capture_clock_oe = st.cap_oe;
	assign sleep_active = st.sleep;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_st = st;
		// three-stage pin sampling; a level counts once stages two and three agree
		next_st.csq = {st.csq[1:0], port_select_low};
		next_st.sckq = {st.sckq[1:0], shift_clock_format_strap};
		next_st.sdiq = {st.sdiq[1:0], serial_line_sleep_strap_in};
		next_st.modq = {st.modq[1:0], output_float_control};
		if (st.csq[2] == st.csq[1])
			next_st.cs_lvl = st.csq[2];
		if (st.sdiq[2] == st.sdiq[1])
			next_st.sdi_lvl = st.sdiq[2];
		if (st.modq[2] == st.modq[1])
			next_st.mod_lvl = st.modq[2];
		if (st.sckq[2] == st.sckq[1])
			next_st.sck_lvl = st.sckq[2];
		sck_rise = (st.sckq[2] == st.sckq[1]) && st.sckq[2] && !st.sck_lvl;
		sck_fall = (st.sckq[2] == st.sckq[1]) && !st.sckq[2] && st.sck_lvl;
		cs_rise = (st.csq[2] == st.csq[1]) && st.csq[2] && !st.cs_lvl;
		if (!st.cs_lvl)
			next_st.spi_seen = 1'b1;
		// sample tick at half the clock; the capture clock runs from it
		next_st.div = !st.div;
		tick = st.div;
		next_st.sleep = st.spi_seen ? (st.act_outmode[1:0] != 2'h0) : st.sdi_lvl;
		fl = st.sleep || (st.spi_seen && st.act_outmode[`ADB_OEB_MSB:`ADB_OEB_LSB] == `ADB_OEB_SEL
			&& st.mod_lvl);
		next_st.doe = !fl;
		next_st.cap_oe = !fl;
		next_st.cap = !tick ^ st.act_clkpol[`ADB_CLKPOL_BIT];
		adv = tick && f_in_ready;
		pop_ok = tick && !fl;
		next_st.rdy = f_in_ready;
		// data source and formatter
		fmt = st.spi_seen ? adb_pkg::adb_fmt_t'(st.act_format[1:0])
			: (st.sck_lvl ? adb_pkg::ADB_FMT_TWOS : adb_pkg::ADB_FMT_OFFSET);
		word = '0;
		raw = sample_code;
		if (sample_over)
			raw = `ADB_CODE_POSFS;
		else if (sample_under)
			raw = `ADB_CODE_NEGFS;
		case (st.act_testpat[3:0])
			`ADB_TP_MID: raw = `ADB_CODE_MID;
			`ADB_TP_POSFS: raw = `ADB_CODE_POSFS;
			`ADB_TP_NEGFS: raw = `ADB_CODE_NEGFS;
			`ADB_TP_CHECK: raw = st.alt ? ~`ADB_CODE_CHECK : `ADB_CODE_CHECK;
			`ADB_TP_PN_LONG: raw = st.pn_long;
			`ADB_TP_PN_SHORT: raw = {1'b0, st.pn_short};
			`ADB_TP_TOGGLE: raw = st.alt ? `ADB_CODE_POSFS : `ADB_CODE_NEGFS;
			default: raw = raw;
		endcase
		case (fmt)
			adb_pkg::ADB_FMT_TWOS: fmtd = {~raw[9], raw[8:0]};
			adb_pkg::ADB_FMT_GRAY: fmtd = raw ^ {1'b0, raw[9:1]};
			default: fmtd = raw;
		endcase
		word = {(st.act_testpat[3:0] == 4'h0) && (sample_over || sample_under), fmtd};
		if (st.self_test_run)
			word = {1'b0, st.self_test_pn};
		crc_new = crc_step(st.crc, st.self_test_pn);
		if (adv)
		begin
			next_st.pipe = {st.pipe[`ADB_PIPE_STAGES-2:0], word};
			next_st.alt = !st.alt;
			next_st.pn_long = {st.pn_long[8:0], st.pn_long[9] ^ st.pn_long[6]};
			next_st.pn_short = {st.pn_short[7:0], st.pn_short[8] ^ st.pn_short[4]};
			if (st.self_test_run)
			begin
				next_st.self_test_pn = {st.self_test_pn[8:0], st.self_test_pn[9] ^ st.self_test_pn[6]};
				next_st.crc = crc_new;
				next_st.self_test_cnt = st.self_test_cnt + 10'h001;
				if (st.self_test_cnt == `ADB_SELF_TEST_CYCLES - 10'h001)
				begin
					next_st.self_test_run = 1'b0;
					next_st.result[`ADB_PASS_BIT] = crc_new == SELF_TEST_SIGNATURE;
					next_st.act_self_test[`ADB_SELF_TEST_EN_BIT] = 1'b0;
				end
			end
		end
		if (st.act_testpat[`ADB_PN_LONG_RST_BIT])
			next_st.pn_long = `ADB_PN_LONG_SEED;
		if (st.act_testpat[`ADB_PN_SHORT_RST_BIT])
			next_st.pn_short = `ADB_PN_SHORT_SEED;
		if (pop_ok && f_out_valid)
		begin
			next_st.dout = f_out[9:0];
			next_st.oor = f_out[10];
		end
		// serial port
		lsb = st.portcfg[`ADB_LSB_FIRST_BIT];
		bitv = st.sdi_lvl;
		apply = 1'b0;
		byte_in = lsb ? {bitv, st.din[7:1]} : {st.din[6:0], bitv};
		if (sck_rise && !st.cs_lvl)
		begin
			case (st.sp)
				adb_pkg::ADB_SP_IDLE:
				begin
					next_st.instr = lsb ? {bitv, 15'h0000} : {15'h0000, bitv};
					next_st.instr_cnt = 5'h01;
					next_st.sp = adb_pkg::ADB_SP_INSTR;
				end
				adb_pkg::ADB_SP_INSTR:
				begin
					next_st.instr = lsb ? {bitv, st.instr[15:1]} : {st.instr[14:0], bitv};
					next_st.instr_cnt = st.instr_cnt + 5'h01;
					if (st.instr_cnt + 5'h01 == `ADB_INSTR_BITS)
					begin
						next_st.is_read = next_st.instr[15];
						next_st.bytes_left = next_st.instr[14:13];
						next_st.streaming = next_st.instr[14:13] == 2'h3;
						next_st.addr = next_st.instr[12:0];
						next_st.rd = reg_read(st, next_st.instr[12:0]);
						next_st.bit_cnt = 3'h0;
						next_st.sp = adb_pkg::ADB_SP_DATA;
					end
				end
				adb_pkg::ADB_SP_DATA:
				begin
					next_st.din = byte_in;
					next_st.bit_cnt = st.bit_cnt + 3'h1;
					if (st.bit_cnt == `ADB_BYTE_LAST)
					begin
						if (!st.is_read)
						begin
							case (st.addr)
								`ADB_A_PORTCFG: next_st.portcfg = byte_in;
								`ADB_A_OUTMODE: next_st.sh_outmode = byte_in;
								`ADB_A_TESTPAT: next_st.sh_testpat = byte_in;
								`ADB_A_SELF_TEST: next_st.sh_self_test = byte_in;
								`ADB_A_FORMAT: next_st.sh_format = byte_in;
								`ADB_A_CLKPOL: next_st.sh_clkpol = byte_in;
								`ADB_A_TRANSFER: apply = byte_in[`ADB_XFER_BIT];
								default: apply = 1'b0;
							endcase
						end
						next_st.addr = lsb ? st.addr + 13'h0001 : st.addr - 13'h0001;
						next_st.rd = reg_read(st, lsb ? st.addr + 13'h0001 : st.addr - 13'h0001);
						if (!st.streaming)
						begin
							if (st.bytes_left == 2'h0)
								next_st.sp = adb_pkg::ADB_SP_IDLE;
							else
								next_st.bytes_left = st.bytes_left - 2'h1;
						end
					end
				end
				default: next_st.sp = adb_pkg::ADB_SP_IDLE;
			endcase
		end
		if (sck_fall && !st.cs_lvl && st.sp == adb_pkg::ADB_SP_DATA && st.is_read)
		begin
			next_st.sdo = lsb ? st.rd[0] : st.rd[7];
			next_st.rd = lsb ? {1'b0, st.rd[7:1]} : {st.rd[6:0], 1'b0};
		end
		// a paused fixed-length frame keeps its place; a streaming one ends with select
		if (cs_rise && st.streaming && st.sp == adb_pkg::ADB_SP_DATA)
			next_st.sp = adb_pkg::ADB_SP_IDLE;
		next_st.sdo_oe = !st.cs_lvl && st.sp == adb_pkg::ADB_SP_DATA && st.is_read;
		if (apply)
		begin
			next_st.act_outmode = st.sh_outmode;
			next_st.act_testpat = st.sh_testpat;
			next_st.act_self_test = st.sh_self_test;
			next_st.act_format = st.sh_format;
			next_st.act_clkpol = st.sh_clkpol;
			if (st.sh_self_test[`ADB_SELF_TEST_EN_BIT])
			begin
				next_st.self_test_run = 1'b1;
				next_st.self_test_cnt = 10'h000;
				next_st.crc = `ADB_CRC_SEED;
				next_st.result[`ADB_PASS_BIT] = 1'b0;
				if (st.sh_self_test[`ADB_SELF_TEST_SEED_RESET_BIT])
					next_st.self_test_pn = `ADB_PN_LONG_SEED;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.csq <= 3'h7;
			st.cs_lvl <= 1'b1;
			st.sp <= adb_pkg::ADB_SP_IDLE;
			st.pn_long <= `ADB_PN_LONG_SEED;
			st.pn_short <= `ADB_PN_SHORT_SEED;
			st.self_test_pn <= `ADB_PN_LONG_SEED;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	property p_out_on_tick;
		!$stable(st.dout) |-> $past(tick) && $past(f_out_valid);
	endproperty
	a_out_on_tick: assert property (p_out_on_tick) else $error("output word changed off a tick");
	property p_twos;
		fmt == adb_pkg::ADB_FMT_TWOS |-> fmtd[9] != raw[9] && fmtd[8:0] == raw[8:0];
	endproperty
	a_twos: assert property (p_twos) else $error("twos complement code wrong");
	property p_strap_fmt;
		!st.spi_seen && !st.sck_lvl |-> fmt == adb_pkg::ADB_FMT_OFFSET;
	endproperty
	a_strap_fmt: assert property (p_strap_fmt) else $error("strap format not offset binary");
	property p_clamp;
		sample_over && st.act_testpat[3:0] == 4'h0 && !st.self_test_run && fmt != adb_pkg::ADB_FMT_GRAY
			|-> word[10] && (word[9:0] == `ADB_CODE_POSFS || word[9:0] == ~`ADB_CODE_MID);
	endproperty
	a_clamp: assert property (p_clamp) else $error("over-range not clamped or flagged");
	property p_float;
		st.spi_seen && st.act_outmode[`ADB_OEB_MSB:`ADB_OEB_LSB] == `ADB_OEB_SEL && st.mod_lvl
			|=> !data_oe && !data_capture_clock_oe;
	endproperty
	a_float: assert property (p_float) else $error("drivers not floated by mode pin");
	property p_self_test_len;
		st.self_test_run && adv && st.self_test_cnt == `ADB_SELF_TEST_CYCLES - 10'h001 |=> !st.self_test_run;
	endproperty
	a_self_test_len: assert property (p_self_test_len) else $error("self-test run length wrong");
	property p_self_test_result;
		$fell(st.self_test_run) |-> st.result[`ADB_PASS_BIT] == ($past(crc_new) == SELF_TEST_SIGNATURE);
	endproperty
	a_self_test_result: assert property (p_self_test_result) else $error("self-test result bit wrong");
	property p_frame_start;
		st.sp == adb_pkg::ADB_SP_IDLE && !st.cs_lvl && sck_rise |=> st.sp == adb_pkg::ADB_SP_INSTR;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame did not start");
	property p_read_drive;
		st.sp == adb_pkg::ADB_SP_DATA && st.is_read && !st.cs_lvl |=> serial_line_sleep_strap_oe;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read data pin not driven");
	property p_shadow;
		!$stable(st.act_format) |-> $past(apply);
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadowed value applied without transfer");
	c_self_test_pass: cover property ($fell(st.self_test_run) ##0 st.result[`ADB_PASS_BIT]);
	c_read: cover property (st.sp == adb_pkg::ADB_SP_DATA && st.is_read && sck_fall);
	c_stream: cover property (st.streaming && cs_rise);
	c_test_mode: cover property (st.act_testpat[3:0] == `ADB_TP_PN_LONG && pop_ok);
endmodule : adb_backend

// ### tb/adb_host.sv
// serial configuration host model for the converter back end, also driving the strap levels
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module adb_host (
	input wire logic clk,
	input wire logic fmt_strap,
	input wire logic slp_strap,
	input wire logic dev_out,
	input wire logic dev_oe,
	output logic port_select_low,
	output logic sck,
	output logic sdio
);
	logic busy;
	logic ck;
	logic h_out;
	logic h_oe;
	logic last;
	// select idles high so the pins act as straps until the first frame
	initial
	begin
		port_select_low = 1'b1;
		busy = 1'b0;
		ck = 1'b0;
		h_out = 1'b0;
		h_oe = 1'b1;
		last = 1'b0;
	end
	// the shift clock stands still outside frames; idle level doubles as the format strap
	assign sck = busy ? ck : fmt_strap;
	// a released line shows the inverse of its last level, never a stale copy
	assign sdio = dev_oe ? dev_out : (busy ? (h_oe ? h_out : ~last) : slp_strap);
	always @(posedge clk)
	begin
		if (dev_oe || h_oe)
			last <= sdio;
	end

	task half;
		repeat (4) @(negedge clk);
	endtask : half

	// data set while the clock is low, device samples on rise; read sampled late in the high phase
	task bitx(input logic b, output logic r);
		h_out = b;
		half();
		ck = 1'b1;
		repeat (3) @(negedge clk);
		r = sdio;
		@(negedge clk);
		ck = 1'b0;
	endtask : bitx

	task xfer(input logic rd, input logic [12:0] a, input logic [7:0] d, input logic pause, output logic [7:0] q);
		logic [15:0] ins;
		logic r;
		int i;
		ins = {rd, 2'b00, a};
		busy = 1'b1;
		port_select_low = 1'b0;
		half();
		for (i = 15; i >= 0; i--)
			bitx(ins[i], r);
		if (pause)
		begin
			port_select_low = 1'b1;
			repeat (3) half();
			port_select_low = 1'b0;
			half();
		end
		h_oe = !rd;
		for (i = 7; i >= 0; i--)
		begin
			bitx(d[i], r);
			q[i] = r;
		end
		half();
		port_select_low = 1'b1;
		h_oe = 1'b1;
		busy = 1'b0;
		half();
	endtask : xfer
endmodule : adb_host

// ### tb/adb_backend_tb.sv
// self-checking bench of the converter digital back end
`timescale 1ns/1ns
`include "adb_cfg.svh"
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
$display("[FAIL] %s exp %h got %h", nm, e, a); end end

////////////////////////////////////////////////////////////////////////////////
module adb_backend_tb;
	// signature of the reseeded run, worked out here from the generator and crc definitions
	function automatic logic [15:0] sig_calc(input int n);
		logic [9:0] s;
		logic [15:0] c;
		s = `ADB_PN_LONG_SEED;
		c = `ADB_CRC_SEED;
		for (int i = 0; i < n; i++)
		begin
			for (int j = 9; j >= 0; j--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ s[j]) ? `ADB_CRC_POLY : 16'h0000);
			s = {s[8:0], s[9] ^ s[6]};
		end
		return c;
	endfunction : sig_calc
	localparam logic [15:0] SIG = sig_calc(int'(`ADB_SELF_TEST_CYCLES));

	function automatic logic [9:0] fmt(input logic [9:0] v, input logic [1:0] f);
		return (f == 2'h1) ? (v ^ 10'h200) : ((f == 2'h2) ? (v ^ (v >> 1)) : v);
	endfunction : fmt

	logic sys_clk, rst, over, under, fmt_strap, slp_strap, float_pin, sel_low, sck, sdio;
	logic sdo, sdo_oe, ready, data_oe, oor, cap, cap_oe, sleep;
	logic [9:0] code, dout, a, prev;
	logic [7:0] q;
	logic [9:0] tp [3] = '{10'h200, 10'h3ff, 10'h000};
	int miscompares, n_compared, seed_ret;

	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;

	adb_backend #(.SELF_TEST_SIGNATURE(SIG)) dut (.sys_clk(sys_clk), .rst(rst), .sample_code(code),
		.sample_over(over), .sample_under(under), .sample_ready(ready), .port_select_low(sel_low),
		.shift_clock_format_strap(sck), .serial_line_sleep_strap_in(sdio), .serial_line_sleep_strap_out(sdo),
		.serial_line_sleep_strap_oe(sdo_oe), .output_float_control(float_pin), .data_out(dout),
		.data_oe(data_oe), .out_of_range(oor), .data_capture_clock(cap), .data_capture_clock_oe(cap_oe),
		.sleep_active(sleep));
	adb_host host (.clk(sys_clk), .fmt_strap(fmt_strap), .slp_strap(slp_strap), .dev_out(sdo),
		.dev_oe(sdo_oe), .port_select_low(sel_low), .sck(sck), .sdio(sdio));

	task summarize;
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task put(input logic [9:0] c, input logic ov, input logic un);
		@(negedge sys_clk);
		code = c;
		over = ov;
		under = un;
		// long enough for the eight-tick latency of a near-empty fifo, not for the backlog a float leaves in it
		repeat (40) @(negedge sys_clk);
	endtask : put

	task wr(input logic [12:0] ad, input logic [7:0] d, input logic p);
		host.xfer(1'b0, ad, d, p, q);
	endtask : wr

	// shadowed registers take effect only with the transfer write
	task apply(input logic [12:0] ad, input logic [7:0] d);
		wr(ad, d, 1'b0);
		wr(`ADB_A_TRANSFER, 8'h01, 1'b0);
	endtask : apply

	initial
	begin
		#3000000;
		miscompares++;
		summarize();
	end

	initial
	begin
		{rst, over, under, fmt_strap, slp_strap, float_pin} = 6'b100000;
		code = 10'h000;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		seed_ret = $urandom(32'hcc90);
		a = 10'($urandom());
		put(a, 1'b0, 1'b0);
		`CHK("strap offset", a, dout)
		fmt_strap = 1'b1;
		a = 10'($urandom());
		put(a, 1'b0, 1'b0);
		`CHK("strap twos", a ^ 10'h200, dout)
		put(10'($urandom()), 1'b1, 1'b0);
		`CHK("over clamp", 11'h5ff, {oor, dout})
		put(10'($urandom()), 1'b0, 1'b1);
		`CHK("under clamp", 11'h600, {oor, dout})
		put(a, 1'b0, 1'b0);
		code = a ^ 10'h155;
		repeat (15) @(negedge sys_clk);
		`CHK("latency early", a ^ 10'h200, dout)
		repeat (3) @(negedge sys_clk);
		`CHK("latency due", a ^ 10'h355, dout)
		slp_strap = 1'b1;
		repeat (10) @(negedge sys_clk);
		`CHK("sleep strap", 2'b10, {sleep, data_oe})
		slp_strap = 1'b0;
		fmt_strap = 1'b0;
		repeat (10) @(negedge sys_clk);
		wr(`ADB_A_FORMAT, 8'h01, 1'b1);
		a = 10'($urandom());
		put(a, 1'b0, 1'b0);
		`CHK("pending", a, dout)
		wr(`ADB_A_TRANSFER, 8'h01, 1'b0);
		put(a, 1'b0, 1'b0);
		`CHK("serial twos", fmt(a, 2'h1), dout)
		apply(`ADB_A_FORMAT, 8'h02);
		put(a, 1'b0, 1'b0);
		`CHK("serial gray", fmt(a, 2'h2), dout)
		host.xfer(1'b1, `ADB_A_FORMAT, 8'h00, 1'b0, q);
		`CHK("read format", 8'h02, q)
		host.xfer(1'b1, 13'h013, 8'h00, 1'b0, q);
		`CHK("read unmapped", 8'h00, q)
		apply(`ADB_A_FORMAT, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			apply(`ADB_A_CLKPOL, {k[0], 7'h00});
			prev = dout;
			for (int i = 0; i < 40; i++)
			begin
				@(negedge sys_clk);
				code = 10'($urandom());
				if (dout !== prev)
					`CHK("capture level at update", k[0], cap)
				prev = dout;
			end
		end
		for (int p = 1; p <= 3; p++)
		begin
			apply(`ADB_A_TESTPAT, 8'(p));
			put(10'($urandom()), 1'b1, 1'b0);
			`CHK("test pattern", {1'b0, tp[p-1]}, {oor, dout})
		end
		apply(`ADB_A_TESTPAT, 8'h15);
		repeat (40) @(negedge sys_clk);
		`CHK("pn held at seed", `ADB_PN_LONG_SEED, dout)
		apply(`ADB_A_TESTPAT, 8'h00);
		apply(`ADB_A_OUTMODE, 8'h20);
		float_pin = 1'b1;
		repeat (10) @(negedge sys_clk);
		`CHK("float drivers", 2'b00, {data_oe, cap_oe})
		repeat (60) @(negedge sys_clk);
		`CHK("fifo full", 1'b0, ready)
		float_pin = 1'b0;
		repeat (10) @(negedge sys_clk);
		`CHK("drive again", 2'b11, {data_oe, cap_oe})
		apply(`ADB_A_SELF_TEST, 8'h05);
		repeat (100) @(negedge sys_clk);
		`CHK("outputs during test", 1'b1, data_oe)
		repeat (1200) @(negedge sys_clk);
		host.xfer(1'b1, `ADB_A_RESULT, 8'h00, 1'b0, q);
		`CHK("self-test pass", 1'b1, q[`ADB_PASS_BIT])
		apply(`ADB_A_SELF_TEST, 8'h01);
		repeat (1300) @(negedge sys_clk);
		host.xfer(1'b1, `ADB_A_RESULT, 8'h00, 1'b0, q);
		`CHK("self-test no reseed", 1'b0, q[`ADB_PASS_BIT])
		summarize();
	end
endmodule : adb_backend_tb
